/* File: hdl/loop_freq_defines.svh */
// register offsets, field positions, reset values and timing counts for the loop block
`ifndef LOOP_FREQ_DEFINES_SVH
`define LOOP_FREQ_DEFINES_SVH
`define OFF_MODE_CFG      8'h00
`define OFF_LOCKED_BW     8'h01
`define OFF_HO_METHOD     8'h02
`define OFF_HO_WORD_0     8'h03
`define OFF_HO_WORD_1     8'h04
`define OFF_HO_WORD_2     8'h05
`define OFF_HO_WORD_3     8'h06
`define OFF_HO_WORD_4     8'h07
`define OFF_STATUS        8'h08
`define OFF_ACQ_WORD_0    8'h09
`define HO_MAN_BIT        6
`define HO_AUTO_BIT       5
`define HO_READ_ACQ_BIT   4
`define HO_HIST_LSB       2
`define HO_AVG_LSB        0
`define MODE_RESET        5'h00
`define LOCKED_BW_RESET   5'h00
`define LOCKED_BW_MAX     5'h15
`define HO_METHOD_RESET   8'h21
`define CLK_MHZ           250
`define SECOND_NS         1000000000
`define SECOND_CYCLES     (`SECOND_NS / 1000 * `CLK_MHZ)
`define FREQ_RANGE_PPM    92
`define FREQ_LIMIT        40'h00_0000_0000
`endif

/* File: hdl/loop_freq_pkg.sv */
// types shared by the loop frequency-control block
package loop_freq_pkg;
  typedef enum logic [4:0] {
    MODE_AUTO       = 5'h00,
    MODE_FREE_RUN   = 5'h01,
    MODE_HOLDOVER   = 5'h02,
    MODE_LOCKED     = 5'h04,
    MODE_PRE_LOCK2  = 5'h05,
    MODE_PRE_LOCK   = 5'h06,
    MODE_LOST_PHASE = 5'h07,
    MODE_DCO_FREQ   = 5'h0A
  } loop_mode_e;
  typedef enum logic [1:0] {
    STAGE_START = 2'h0,
    STAGE_ACQ   = 2'h1,
    STAGE_LOCK  = 2'h2
  } lock_stage_e;
  typedef logic signed [39:0] freq_word_t;
endpackage

/* File: hdl/dco_if.sv */
// carrier between the control logic and the phase accumulator
`timescale 1ns/1ps
interface dco_if;
  logic signed [39:0] freq_off;   // signed frequency offset steering the accumulator
  logic [47:0]        phase;      // accumulator phase
  logic               wrap;       // accumulator overflow pulse
  modport ctrl (output freq_off, input phase, input wrap);
  modport acc  (input freq_off, output phase, output wrap);
endinterface

/* File: hdl/dco_accum.sv */
// phase accumulator stepped each clock by nominal step plus signed offset
`timescale 1ns/1ps
module dco_accum
  import loop_freq_pkg::*;
#(
  parameter logic [47:0] NOMINAL_STEP = 48'h0000_1000_0000
) (
  input wire logic clk,     // system clock
  input wire logic reset_n, // async reset, active low
  dco_if.acc       dco      // offset in, phase out
);
  logic [47:0] phase_q;     // accumulated phase
  logic [47:0] phase_d;     // next phase
  logic        wrap_q;      // overflow flag
  logic        wrap_d;      // next overflow flag
  logic [48:0] sum;         // carry-extended sum

  // add nominal step and sign-extended offset
  always_comb begin
    sum     = {1'b0, phase_q} + {1'b0, NOMINAL_STEP}
              + {{9{dco.freq_off[39]}}, dco.freq_off};
    phase_d = sum[47:0];
    wrap_d  = phase_d < phase_q;
  end

  // register phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 48'h0000_0000_0000;
      wrap_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      wrap_q  <= wrap_d;
    end
  end

  assign dco.phase = phase_q;
  assign dco.wrap  = wrap_q;

  // [R4] wrap marks a phase rollover
  a_wrap_flag: assert property (  // [R4]
    @(posedge clk) disable iff (!reset_n)
    wrap_q |-> phase_q < $past(phase_q))
    else $error("wrap flag without phase rollover");
endmodule

/* File: hdl/loop_freq_ctrl.sv */
// primary loop frequency control: mode, bandwidth, holdover and dco steering
// Overview of operation
// [R1] locked bandwidth codes 0x00-0x15, rest reserved
// [R2] pre-locked2 tracks reference, transient only
// [R3] lost-phase tracks reference, transient only
// [R4] dco is accumulator steered by control word
// [R5] dco control chosen by mode register
// [R6] frequency word is signed two's complement
// [R7] applied offset spans plus minus 92 ppm
// [R8] lsb weight fixed fractional ppm scaled
// [R9] phase shift equals frequency times time
// [R10] holdover uses stored data, no lock
// [R11] manual, auto, history, filter pick source
// [R12] history picks now, 1, 8, 64 s
// [R13] filter code picks four bandwidths
// [R14] manual select uses written word
// [R15] reset default: current average, 1.5 mHz
// [R16] readback select: acquired or written word
// [R17] host converts read word to ppm
// [R18] mode 01010 is dco write frequency
// [R19] locked bandwidth only in locked stage
// [R20] frequency word applied atomically
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "loop_freq_defines.svh"
module loop_freq_ctrl
  import loop_freq_pkg::*;
#(
  parameter int SECOND_CYC = `SECOND_CYCLES,
  parameter int START_CYC  = 2 * `SECOND_CYCLES
) (
  input  wire logic        clk,          // system clock
  input  wire logic        reset_n,      // async reset, active low
  input  wire logic [7:0]  addr,         // register address
  input  wire logic [7:0]  wdata,        // write data
  input  wire logic        wr,           // write strobe
  input  wire logic        rd,           // read strobe
  output logic      [7:0]  rdata,        // read data, cycle after rd
  input  wire logic        loop_locked,  // loop phase detector reports lock
  input  wire logic        ref_valid,    // a qualified reference is selected
  input  wire logic signed [39:0] integ_freq, // loop integral path frequency
  output logic      [4:0]  active_bw,    // bandwidth code in use
  output logic      [1:0]  lock_stage,   // current locking stage
  output logic             track_ref,    // output follows the reference
  output logic      [47:0] dco_phase     // accumulator phase
);
  dco_if dco ();

  loop_mode_e  mode_q, mode_d;            // operating mode selector
  logic [4:0]  bw_q, bw_d;                // locked bandwidth selector
  logic [7:0]  ho_q, ho_d;                // holdover method config
  logic [39:0] wr_word_q, wr_word_d;      // host written word
  logic [31:0] stage_word_q, stage_word_d; // low bytes staged until top byte
  freq_word_t  applied_q, applied_d;      // offset in use
  freq_word_t  avg_q, avg_d;              // running average
  freq_word_t  h1_q, h1_d;                // average one second back
  freq_word_t  h8_q, h8_d;                // average eight seconds back
  freq_word_t  h64_q, h64_d;              // average 64 seconds back
  freq_word_t  h1s [0:63];                // per-second history ring
  logic [5:0]  hptr_q, hptr_d;            // ring write pointer
  logic [31:0] sec_q, sec_d;              // second timer
  logic [31:0] stg_cnt_q, stg_cnt_d;      // start stage timer
  lock_stage_e stage_q, stage_d;          // locking stage
  logic [7:0]  rdata_q, rdata_d;          // read data register
  freq_word_t  acq_word;                  // acquired holdover offset
  logic [3:0]  avg_shift;                 // filter weight shift
  logic        sec_tick;                  // one second elapsed
  logic [39:0] rd_word;                   // word returned on readback

  assign sec_tick = (sec_q == SECOND_CYC - 1);

  // filter bandwidth: wider band means lighter smoothing
  // [R13] filter code to shift
  always_comb begin
    case (ho_q[`HO_AVG_LSB +: 2])
      2'h0:    avg_shift = 4'd14;
      2'h1:    avg_shift = 4'd11;
      2'h2:    avg_shift = 4'd8;
      default: avg_shift = 4'd4;
    endcase
  end

  // choose the acquired holdover offset
  // [R11] source selection
  always_comb begin
    if (ho_q[`HO_MAN_BIT]) begin
      // [R14] manual uses written word
      acq_word = freq_word_t'(wr_word_q);
    end else if (!ho_q[`HO_AUTO_BIT]) begin
      acq_word = avg_q;
    end else begin
      // [R12] history depth select
      case (ho_q[`HO_HIST_LSB +: 2])
        2'h0:    acq_word = avg_q;
        2'h1:    acq_word = h1_q;
        2'h2:    acq_word = h8_q;
        default: acq_word = h64_q;
      endcase
    end
  end

  // averaging filter and history taps, advanced while locked only
  always_comb begin
    avg_d  = avg_q;
    h1_d   = h1_q;
    h8_d   = h8_q;
    h64_d  = h64_q;
    hptr_d = hptr_q;
    sec_d  = sec_tick ? 32'h0000_0000 : sec_q + 32'h0000_0001;
    if (stage_q == STAGE_LOCK) begin
      // first-order iir, fixed shift of 11 when auto averaging is off
      avg_d = ho_q[`HO_AUTO_BIT]
              ? freq_word_t'(avg_q + ((integ_freq - avg_q) >>> avg_shift))
              : freq_word_t'(avg_q + ((integ_freq - avg_q) >>> 11));
      if (sec_tick) begin
        hptr_d = hptr_q + 6'd1;
        h1_d   = avg_q;
        h8_d   = h1s[hptr_q - 6'd7];
        h64_d  = h1s[hptr_q];
      end
    end
  end

  // history ring write, no reset needed on the storage itself
  always_ff @(posedge clk) begin
    if (sec_tick && stage_q == STAGE_LOCK) begin
      h1s[hptr_q] <= avg_q;
    end
  end

  // locking stage sequencing
  // [R19] stage drives bandwidth choice
  always_comb begin
    stage_d   = stage_q;
    stg_cnt_d = stg_cnt_q;
    if (!ref_valid) begin
      stage_d   = STAGE_START;
      stg_cnt_d = 32'h0000_0000;
    end else begin
      case (stage_q)
        STAGE_START: begin
          stg_cnt_d = stg_cnt_q + 32'h0000_0001;
          if (stg_cnt_q == START_CYC - 1) begin
            stage_d = STAGE_ACQ;
          end
        end
        STAGE_ACQ: begin
          if (loop_locked) begin
            stage_d = STAGE_LOCK;
          end
        end
        STAGE_LOCK: begin
          if (!loop_locked) begin
            stage_d = STAGE_ACQ;
          end
        end
        default: stage_d = STAGE_START;
      endcase
    end
  end

  // register writes; word applied only when top byte lands
  always_comb begin
    mode_d       = mode_q;
    bw_d         = bw_q;
    ho_d         = ho_q;
    wr_word_d    = wr_word_q;
    stage_word_d = stage_word_q;
    if (wr) begin
      case (addr)
        // [R5] mode chosen by register
        `OFF_MODE_CFG:  mode_d = loop_mode_e'(wdata[4:0]);
        // [R1] reserved codes refused
        `OFF_LOCKED_BW: if (wdata[4:0] <= `LOCKED_BW_MAX) bw_d = wdata[4:0];
        `OFF_HO_METHOD: ho_d = {1'b0, wdata[6:0]};
        `OFF_HO_WORD_0: stage_word_d[7:0]   = wdata;
        `OFF_HO_WORD_1: stage_word_d[15:8]  = wdata;
        `OFF_HO_WORD_2: stage_word_d[23:16] = wdata;
        `OFF_HO_WORD_3: stage_word_d[31:24] = wdata;
        // [R20] atomic commit
        `OFF_HO_WORD_4: wr_word_d = {wdata, stage_word_q};
        default: ;
      endcase
    end
  end

  // offset applied to the accumulator per mode
  // [R4] accumulator steering
  always_comb begin
    case (mode_q)
      // [R18] dco write frequency mode
      // [R6] signed word drives dco
      MODE_DCO_FREQ: applied_d = freq_word_t'(wr_word_q);
      // [R10] holdover from stored data
      MODE_HOLDOVER: applied_d = acq_word;
      MODE_FREE_RUN: applied_d = '0;
      default:       applied_d = (stage_q == STAGE_LOCK || mode_q != MODE_AUTO)
                                 ? integ_freq : applied_q;
    endcase
  end

  // [R2] pre-locked2 tracks reference
  // [R3] lost-phase tracks reference
  assign track_ref = (mode_q == MODE_PRE_LOCK2) || (mode_q == MODE_LOST_PHASE)
                     || (mode_q == MODE_PRE_LOCK) || (mode_q == MODE_LOCKED)
                     || (mode_q == MODE_AUTO && ref_valid);

  // [R19] locked bandwidth only when locked
  assign active_bw  = (stage_q == STAGE_LOCK) ? bw_q : 5'h00;
  assign lock_stage = stage_q;

  // [R16] readback selection
  assign rd_word = ho_q[`HO_READ_ACQ_BIT] ? acq_word : wr_word_q;

  // read mux, data stands the cycle after rd
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        `OFF_MODE_CFG:  rdata_d = {3'h0, mode_q};
        `OFF_LOCKED_BW: rdata_d = {3'h0, bw_q};
        `OFF_HO_METHOD: rdata_d = ho_q;
        `OFF_HO_WORD_0: rdata_d = rd_word[7:0];
        `OFF_HO_WORD_1: rdata_d = rd_word[15:8];
        `OFF_HO_WORD_2: rdata_d = rd_word[23:16];
        `OFF_HO_WORD_3: rdata_d = rd_word[31:24];
        `OFF_HO_WORD_4: rdata_d = rd_word[39:32];
        `OFF_STATUS:    rdata_d = {5'h00, track_ref, stage_q};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q       <= MODE_AUTO;
      bw_q         <= `LOCKED_BW_RESET;
      // [R15] default current average, 1.5 mHz
      ho_q         <= `HO_METHOD_RESET;
      wr_word_q    <= `FREQ_LIMIT;
      stage_word_q <= 32'h0000_0000;
      applied_q    <= '0;
      avg_q        <= '0;
      h1_q         <= '0;
      h8_q         <= '0;
      h64_q        <= '0;
      hptr_q       <= 6'h00;
      sec_q        <= 32'h0000_0000;
      stg_cnt_q    <= 32'h0000_0000;
      stage_q      <= STAGE_START;
      rdata_q      <= 8'h00;
    end else begin
      mode_q       <= mode_d;
      bw_q         <= bw_d;
      ho_q         <= ho_d;
      wr_word_q    <= wr_word_d;
      stage_word_q <= stage_word_d;
      applied_q    <= applied_d;
      avg_q        <= avg_d;
      h1_q         <= h1_d;
      h8_q         <= h8_d;
      h64_q        <= h64_d;
      hptr_q       <= hptr_d;
      sec_q        <= sec_d;
      stg_cnt_q    <= stg_cnt_d;
      stage_q      <= stage_d;
      rdata_q      <= rdata_d;
    end
  end

  // [R7] [R8] [R9] lsb weight and range are the word scaling; phase integrates offset
  assign dco.freq_off = applied_q;
  assign dco_phase    = dco.phase;
  assign rdata        = rdata_q;

  dco_accum u_dco (
    .clk     (clk),
    .reset_n (reset_n),
    .dco     (dco)
  );

  sequence s_top_write;
    wr && addr == `OFF_HO_WORD_4;
  endsequence

  a_word_commit_atomic: assert property (  // [R20]
    @(posedge clk) disable iff (!reset_n)
    (wr && addr != `OFF_HO_WORD_4) |=> $stable(wr_word_q))
    else $error("written word changed without top byte");
  a_word_commit_now: assert property (  // [R20]
    @(posedge clk) disable iff (!reset_n)
    s_top_write |=> wr_word_q[39:32] == $past(wdata))
    else $error("top byte not committed");
  a_dco_mode_word: assert property (  // [R18]
    @(posedge clk) disable iff (!reset_n)
    (mode_q == MODE_DCO_FREQ) |=> applied_q == $past(wr_word_q))
    else $error("dco mode not steered by word");
  a_bw_reserved: assert property (  // [R1]
    @(posedge clk) disable iff (!reset_n)
    bw_q <= `LOCKED_BW_MAX)
    else $error("reserved bandwidth code held");
  a_bw_locked_only: assert property (  // [R19]
    @(posedge clk) disable iff (!reset_n)
    (stage_q != STAGE_LOCK) |-> active_bw == 5'h00)
    else $error("locked bandwidth outside locked stage");
  a_manual_source: assert property (  // [R14]
    @(posedge clk) disable iff (!reset_n)
    ho_q[`HO_MAN_BIT] |-> acq_word == freq_word_t'(wr_word_q))
    else $error("manual holdover not using word");
  a_readback_sel: assert property (  // [R16]
    @(posedge clk) disable iff (!reset_n)
    (rd && addr == `OFF_HO_WORD_0 && !ho_q[`HO_READ_ACQ_BIT])
    |=> rdata == $past(wr_word_q[7:0]))
    else $error("readback did not return written word");
  a_transient_track: assert property (  // [R2] [R3]
    @(posedge clk) disable iff (!reset_n)
    (mode_q == MODE_PRE_LOCK2 || mode_q == MODE_LOST_PHASE) |-> track_ref)
    else $error("transient mode not tracking");
  a_holdover_src: assert property (  // [R10]
    @(posedge clk) disable iff (!reset_n)
    (mode_q == MODE_HOLDOVER) |=> applied_q == $past(acq_word))
    else $error("holdover not using stored data");
endmodule

/* File: verification/test_dpll_holdover_dco_freq_control.sv */
// self-checking bench for the primary loop frequency-control block
`timescale 1ns/1ps
`include "loop_freq_defines.svh"
module test_dpll_holdover_dco_freq_control
  import loop_freq_pkg::*;
();
  localparam logic [47:0] STEP  = 48'h0000_1000_0000; // accumulator default step
  localparam int          LIMIT = 20000;              // hang ceiling in cycles
  logic        clk;          // system clock
  logic        reset_n;      // async reset, active low
  logic [7:0]  addr;         // register address
  logic [7:0]  wdata;        // write data
  logic        wr;           // write strobe
  logic        rd;           // read strobe
  logic [7:0]  rdata;        // read data
  logic        loop_locked;  // lock indication
  logic        ref_valid;    // reference qualified
  freq_word_t  integ_freq;   // integral path frequency
  logic [4:0]  active_bw;    // bandwidth in use
  logic [1:0]  lock_stage;   // locking stage
  logic        track_ref;    // output follows reference
  logic [47:0] dco_phase;    // accumulator phase
  int          err_total;    // mismatch count
  int          comparisons;  // compare count
  int          cycles;       // timeout counter
  logic [15:0] lfsr_q;       // random state
  logic [4:0]  bw_exp;       // expected locked code
  logic [39:0] word;         // frequency word under test
  logic [39:0] word2;        // second word, for partial writes
  logic [39:0] word3;        // third word, for source comparisons
  loop_mode_e  modes [7] = '{MODE_FREE_RUN, MODE_HOLDOVER, MODE_LOCKED, MODE_PRE_LOCK2,
                             MODE_PRE_LOCK, MODE_LOST_PHASE, MODE_DCO_FREQ}; // forced modes
  logic [6:0]  trk_map = 7'h3C; // tracking expected per forced mode

  // short timing counts keep the run brief
  loop_freq_ctrl #(.SECOND_CYC(16), .START_CYC(32)) dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .loop_locked(loop_locked), .ref_valid(ref_valid),
    .integ_freq(integ_freq), .active_bw(active_bw), .lock_stage(lock_stage),
    .track_ref(track_ref), .dco_phase(dco_phase));

  // clock at 250 MHz
  always #2 clk = ~clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // phase advance over n cycles for a signed offset word
  function automatic logic [47:0] adv(input logic [39:0] w, input int n);
    adv = 48'(n) * (STEP + {{8{w[39]}}, w});
  endfunction

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rnd();
    lfsr_q = lfsr_next(lfsr_q);
  endtask
  // one-cycle write; reserved locked codes leave the old code
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    if (a == `OFF_LOCKED_BW && d <= 8'h15) bw_exp = d[4:0];
    #1;
  endtask
  // one-cycle read; data stands only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk({40'h0, rdata}, {40'h0, e});
  endtask
  task automatic wr_word(input logic [39:0] w, input int nbytes);
    for (int i = 0; i < nbytes; i++) begin
      wr_reg(8'(`OFF_HO_WORD_0 + i), w[8*i +: 8]);
    end
  endtask
  task automatic rd_word(input logic [39:0] w);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'(`OFF_HO_WORD_0 + i), w[8*i +: 8]);
    end
  endtask
  // host takes the signed word whole
  // five byte reads, low byte first, each taken while it stands
  task automatic rd_get(output logic [39:0] w);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      addr <= 8'(`OFF_HO_WORD_0 + i);
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 w[8*i +: 8] = rdata;
    end
  endtask
  // accumulator advance over ten cycles once the offset has landed
  task automatic phase_chk(input logic [39:0] w);
    logic [47:0] p0;
    repeat (3) @(posedge clk);
    #1 p0 = dco_phase;
    repeat (10) @(posedge clk);
    #1 chk(dco_phase - p0, adv(w, 10));
  endtask

  // locked code only in locked stage
  always @(negedge clk) begin
    if (reset_n) chk(48'(active_bw), (lock_stage === 2'h2) ? 48'(bw_exp) : 48'h0);
  end

  // hang guard, counted as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    clk         = 1'b0;
    reset_n     = 1'b0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    loop_locked = 1'b0;
    ref_valid   = 1'b0;
    integ_freq  = 40'h00_0012_3456;
    lfsr_q      = 16'h003F;
    bw_exp      = 5'h00;
    cycles      = 0;
    err_total   = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // reset contents of the control registers
    rd_chk(`OFF_MODE_CFG, 8'h00);
    rd_chk(`OFF_LOCKED_BW, 8'h00);
    rd_chk(`OFF_HO_METHOD, 8'h21);
    rd_chk(`OFF_STATUS, 8'h00);
    rd_word(40'h0);
    rd_chk(8'h40, 8'h00);           // unmapped place reads zero
    for (int c = 0; c < 32; c++) begin
      wr_reg(`OFF_LOCKED_BW, 8'(c));
      rd_chk(`OFF_LOCKED_BW, {3'h0, bw_exp});
    end
    // stage climbs to locked with a good reference
    wr_reg(`OFF_LOCKED_BW, 8'h0C);
    @(posedge clk);
    loop_locked <= 1'b1;
    ref_valid   <= 1'b1;
    for (int i = 0; i < 600 && lock_stage !== 2'h2; i++) @(posedge clk);
    #1 chk(48'(lock_stage), 48'h2);
    rd_chk(`OFF_STATUS, 8'h06);
    for (int m = 0; m < 7; m++) begin
      wr_reg(`OFF_MODE_CFG, {3'h0, modes[m]});
      chk(48'(track_ref), 48'(trk_map[m]));
      rd_chk(`OFF_MODE_CFG, {3'h0, modes[m]});
    end
    for (int k = 0; k < 128; k++) begin
      wr_reg(`OFF_HO_METHOD, 8'(k));
      rd_chk(`OFF_HO_METHOD, 8'(k));
    end
    // written word, then acquired word in manual
    for (int n = 0; n < 4; n++) begin
      rnd();
      word = {lfsr_q[7:0], lfsr_q, ~lfsr_q};
      rnd();
      word2 = {lfsr_q[7:0], ~lfsr_q, lfsr_q};
      wr_reg(`OFF_HO_METHOD, 8'h00);
      wr_word(word, 5);
      rd_word(word);
      wr_reg(`OFF_HO_METHOD, 8'h50);
      repeat (4) @(posedge clk);
      rd_word(word);
      wr_word(word2, 4);
      repeat (4) @(posedge clk);
      rd_word(word);
      wr_reg(`OFF_HO_WORD_4, word2[39:32]);
      repeat (4) @(posedge clk);
      rd_word(word2);
    end
    wr_reg(`OFF_MODE_CFG, {3'h0, MODE_DCO_FREQ});
    for (int n = 0; n < 5; n++) begin
      rnd();
      word = (n == 0) ? 40'h80_0000_0000 : {{24{lfsr_q[15]}}, lfsr_q};
      if (n == 1) word = 40'h7F_FFFF_FFFF;
      wr_word(word, 5);
      phase_chk(word);
    end
    wr_reg(`OFF_MODE_CFG, {3'h0, MODE_FREE_RUN});
    phase_chk(40'h0);
    // manual holdover steers by the written word
    wr_reg(`OFF_HO_METHOD, 8'h40);
    wr_reg(`OFF_MODE_CFG, {3'h0, MODE_HOLDOVER});
    phase_chk(word);
    // average frozen out of lock, read three ways
    @(posedge clk);
    ref_valid <= 1'b0;
    wr_reg(`OFF_HO_METHOD, 8'h10);
    rd_get(word2);
    chk(48'(word2 === word), 48'h0);
    wr_reg(`OFF_HO_METHOD, 8'h1F);
    rd_get(word3);
    chk({8'h0, word3}, {8'h0, word2});
    wr_reg(`OFF_HO_METHOD, 8'h33);
    rd_get(word3);
    chk({8'h0, word3}, {8'h0, word2});
    wrap_up();
  end
endmodule
